//--- inc/gtpc_pkg.sv
// package: register map, field layouts and timing constants of the gated timer
package gtpc_pkg;

  // ==========================================================================
  // register map (byte addresses on the avalon slave)
  // ==========================================================================
  localparam int               ADDR_W             = 5;
  localparam logic [4:0]       ADDR_COUNT_LOW     = 5'h00;
  localparam logic [4:0]       ADDR_COUNT_HIGH    = 5'h04;
  localparam logic [4:0]       ADDR_COMP_AUX      = 5'h08;
  localparam logic [4:0]       ADDR_STATUS        = 5'h0C;
  localparam logic [4:0]       ADDR_CONTROL       = 5'h10;

  // ==========================================================================
  // reset values and field positions
  // ==========================================================================
  localparam logic [7:0]       CONTROL_RESET      = 8'h00;
  localparam logic [7:0]       COMP_AUX_RESET     = 8'h02;
  localparam logic [7:0]       COMP_AUX_MASK      = 8'h02;
  localparam int               GATE_SRC_BIT       = 1;
  localparam int               STAT_COUNTING_BIT  = 0;
  localparam int               STAT_GATE_BIT      = 1;
  localparam int               STAT_LP_ROUTE_BIT  = 2;
  localparam logic [15:0]      COUNT_RESET        = 16'h0000;
  localparam logic [15:0]      COUNT_MAX          = 16'hFFFF;
  localparam logic [31:0]      UNMAPPED_READ      = 32'h0000_0000;

  // ==========================================================================
  // timing: one instruction cycle is four system clocks
  // ==========================================================================
  localparam int               CLK_PERIOD_NS      = 40;
  localparam int               INSTR_PERIOD_NS    = 160;
  localparam int               INSTR_CLKS         =
    (INSTR_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]       INSTR_LAST         = 2'(INSTR_CLKS - 1);

  typedef enum logic [1:0] {
    DIV_BY_1 = 2'b00,
    DIV_BY_2 = 2'b01,
    DIV_BY_4 = 2'b10,
    DIV_BY_8 = 2'b11
  } gtpc_div_type;

  typedef struct packed {
    logic         gate_polarity_invert;
    logic         gate_enable_bit;
    gtpc_div_type input_divider_select;
    logic         low_power_osc_enable;
    logic         external_sync_disable;
    logic         clock_source_select;
    logic         timer_run_bit;
  } gtpc_ctl_type;

  typedef struct packed {
    logic external_count_input;
    logic lp_osc_input;
    logic gate_input_pin;
    logic comparator_result;
  } gtpc_pins_type;

  typedef struct packed {
    logic [15:0] count;
    logic        overflow_pulse;
    logic        wake_request;
    logic        counting;
  } gtpc_status_type;

endpackage

//--- hdl/gtpc_timer.sv
// gated 16-bit timer with input divider, gate control and avalon register slave
module gtpc_timer (
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic [gtpc_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [31:0]               writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [31:0]               readdata,
  output logic                           waitrequest,
  input  wire gtpc_pkg::gtpc_pins_type   pins,
  input  wire logic                      sleep_mode,
  input  wire logic                      internal_oscillator_no_clkout,
  output gtpc_pkg::gtpc_status_type      status
);
  import gtpc_pkg::*;

  // ==========================================================================
  // avalon slave: one wait state on every access
  // ==========================================================================
  logic         ack_reg;
  logic         req;
  logic         done;
  logic         lane0;
  logic         wr_ctl;
  logic         wr_aux;
  logic         wr_low;
  logic         wr_high;
  logic         cnt_wr;
  logic [7:0]   rd_byte;
  logic         rd_mapped;
  logic [31:0]  readdata_reg;

  gtpc_ctl_type ctl_reg;
  logic [7:0]   comp_aux_reg;
  logic [15:0]  count_reg;
  logic [2:0]   div_reg;
  logic [2:0]   div_last;
  logic [1:0]   instr_cnt_reg;
  logic         ext_meta_reg;
  logic         ext_sync_reg;
  logic         ext_prev_reg;
  logic         armed_reg;
  logic         ovf_reg;
  logic         wake_reg;

  logic         lp_route;
  logic         ext_raw;
  logic         ext_level;
  logic         ext_rise;
  logic         instr_tick;
  logic         gate_raw;
  logic         gate_level;
  logic         gate_hold;
  logic         awake_ok;
  logic         src_tick;
  logic         count_en;
  logic         div_tick;
  logic         carry;

  assign req         = read | write;
  assign waitrequest = req & ~ack_reg;
  assign done        = req & ack_reg;
  assign lane0       = byteenable[0];
  assign wr_ctl      = write & done & lane0 & (address == ADDR_CONTROL);
  assign wr_aux      = write & done & lane0 & (address == ADDR_COMP_AUX);
  assign wr_low      = write & done & lane0 & (address == ADDR_COUNT_LOW);
  assign wr_high     = write & done & lane0 & (address == ADDR_COUNT_HIGH);
  assign cnt_wr      = wr_low | wr_high;
  assign readdata    = readdata_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= req & ~ack_reg;
  end

  // divider is deliberately absent from the read mux
  always_comb
  begin
    rd_mapped = 1'b1;
    rd_byte   = 8'h00;
    unique case (address)
      ADDR_COUNT_LOW:  rd_byte = count_reg[7:0];
      ADDR_COUNT_HIGH: rd_byte = count_reg[15:8];
      ADDR_COMP_AUX:   rd_byte = comp_aux_reg;
      ADDR_CONTROL:    rd_byte = ctl_reg;
      ADDR_STATUS:
      begin
        rd_byte[STAT_COUNTING_BIT] = count_en;
        rd_byte[STAT_GATE_BIT]     = gate_level;
        rd_byte[STAT_LP_ROUTE_BIT] = lp_route;
      end
      default:         rd_mapped = 1'b0;
    endcase
  end

  // read data is captured in the wait cycle and stands at the accepting edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      readdata_reg <= UNMAPPED_READ;
    else if (read && !ack_reg)
      readdata_reg <= rd_mapped ? {24'h00_0000, rd_byte} : UNMAPPED_READ;
  end

  // ==========================================================================
  // control registers
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctl_reg <= gtpc_ctl_type'(CONTROL_RESET);
    else if (wr_ctl)
      ctl_reg <= gtpc_ctl_type'(writedata[7:0]);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      comp_aux_reg <= COMP_AUX_RESET;
    else if (wr_aux)
      comp_aux_reg <= writedata[7:0] & COMP_AUX_MASK;
  end

  // ==========================================================================
  // count source: external pin, low-power oscillator or instruction clock, optional synchroniser
  // ==========================================================================
  assign lp_route = ctl_reg.low_power_osc_enable & internal_oscillator_no_clkout;
  assign ext_raw  = lp_route ? pins.lp_osc_input
                             : pins.external_count_input;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end
    else
    begin
      ext_meta_reg <= ext_raw;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  // bypass trades two clocks of latency for edges that keep coming in sleep
  assign ext_level = ctl_reg.external_sync_disable ? ext_raw
                                                   : ext_sync_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ext_prev_reg <= 1'b0;
    else
      ext_prev_reg <= ext_level;
  end

  // a low level must be seen before the first counted rising edge
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      armed_reg <= 1'b0;
    else if (!ctl_reg.timer_run_bit || !ctl_reg.clock_source_select)
      armed_reg <= 1'b0;
    else if (!ext_level)
      armed_reg <= 1'b1;
  end

  assign ext_rise = ext_level & ~ext_prev_reg & armed_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      instr_cnt_reg <= 2'b00;
    else
      instr_cnt_reg <= instr_cnt_reg + 2'b01;
  end

  assign instr_tick = (instr_cnt_reg == INSTR_LAST);

  // ==========================================================================
  // gate and run qualification
  // ==========================================================================
  assign gate_raw   = comp_aux_reg[GATE_SRC_BIT] ? pins.gate_input_pin
                                                 : pins.comparator_result;
  assign gate_level = gate_raw ^ ctl_reg.gate_polarity_invert;
  assign gate_hold  = ctl_reg.gate_enable_bit & gate_level;
  // only the unsynchronised external path keeps counting in sleep
  assign awake_ok   = ~sleep_mode | (ctl_reg.clock_source_select
                                     & ctl_reg.external_sync_disable);
  assign src_tick   = ctl_reg.clock_source_select ? ext_rise
                                                  : instr_tick;
  assign count_en   = ctl_reg.timer_run_bit & ~gate_hold & awake_ok;
  assign div_tick   = count_en & src_tick;

  // ==========================================================================
  // input divider
  // ==========================================================================
  always_comb
  begin
    unique case (ctl_reg.input_divider_select)
      DIV_BY_1: div_last = 3'h0;
      DIV_BY_2: div_last = 3'h1;
      DIV_BY_4: div_last = 3'h3;
      DIV_BY_8: div_last = 3'h7;
    endcase
  end

  assign carry = div_tick & (div_reg >= div_last);

  // no bus path loads this counter; count-byte writes and each carry clear it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      div_reg <= 3'h0;
    else if (cnt_wr)
      div_reg <= 3'h0;
    else if (carry)
      div_reg <= 3'h0;
    else if (div_tick)
      div_reg <= div_reg + 3'h1;
  end

  // ==========================================================================
  // 16-bit count; a bus write wins over a same-cycle increment
  // ==========================================================================
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_reg <= COUNT_RESET;
    else if (wr_low)
      count_reg[7:0] <= writedata[7:0];
    else if (wr_high)
      count_reg[15:8] <= writedata[7:0];
    else if (carry)
      count_reg <= count_reg + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ovf_reg  <= 1'b0;
      wake_reg <= 1'b0;
    end
    else
    begin
      ovf_reg  <= carry & ~cnt_wr & (count_reg == COUNT_MAX);
      wake_reg <= carry & ~cnt_wr & (count_reg == COUNT_MAX)
                  & sleep_mode;
    end
  end

  assign status.count          = count_reg;
  assign status.overflow_pulse = ovf_reg;
  assign status.wake_request   = wake_reg;
  assign status.counting       = count_en;

  // ==========================================================================
  // checks
  // ==========================================================================
  div_one_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (div_tick && ctl_reg.input_divider_select == DIV_BY_1 && !cnt_wr)
      |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("divide by one missed an increment");

  div_eight_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (carry && ctl_reg.input_divider_select == DIV_BY_8) |-> div_reg == 3'h7)
    else $error("divide by eight carried early");

  div_stable_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!div_tick && !cnt_wr) |=> $stable(div_reg))
    else $error("divider moved without a tick");

  div_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    cnt_wr |=> div_reg == 3'h0)
    else $error("count write did not clear divider");

  gate_src_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !comp_aux_reg[GATE_SRC_BIT] |-> gate_raw == pins.comparator_result)
    else $error("gate source select ignored");

  gate_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctl_reg.gate_enable_bit |-> !gate_hold)
    else $error("gate acted while disabled");

  gate_inv_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_reg.gate_enable_bit && ctl_reg.gate_polarity_invert && !gate_raw
     && !cnt_wr) |=> $stable(count_reg))
    else $error("inverted gate did not hold count");

  gate_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (gate_hold && !cnt_wr) |=> $stable(count_reg))
    else $error("count moved while gate active");

  sync_lag_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ctl_reg.external_sync_disable |-> ##2 (ctl_reg.external_sync_disable
      || ext_level == $past(ext_raw, 2)))
    else $error("synchronised path lag wrong");

  sleep_stop_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (sleep_mode && !ctl_reg.external_sync_disable && !cnt_wr)
      |=> $stable(count_reg))
    else $error("synchronised counter ran in sleep");

  wake_ovf_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    wake_reg |-> ovf_reg && count_reg == COUNT_RESET)
    else $error("wake without overflow");

  instr_pace_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!ctl_reg.clock_source_select && div_tick)
      |=> (!div_tick || ctl_reg.clock_source_select) [*3])
    else $error("timer ticked faster than instruction cycle");

  ext_edge_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (ctl_reg.clock_source_select && div_tick) |-> ext_level && !ext_prev_reg)
    else $error("external count without rising edge");

  run_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!ctl_reg.timer_run_bit && !cnt_wr) |=> $stable(count_reg))
    else $error("count moved while stopped");

  lp_route_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !internal_oscillator_no_clkout |-> ext_raw == pins.external_count_input)
    else $error("oscillator routed without internal clock");

endmodule // gtpc_timer

//--- dv/gtpc_pin_source.sv
// partner model: external count clock, gate pin and comparator sources
module gtpc_pin_source
  import gtpc_pkg::*;
(
  input  wire logic              clk,
  output gtpc_pkg::gtpc_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // idle levels: count input low so the first rising edge is armed
  // ==========================================================================
  initial
  begin
    pins = '0;
  end

  // called just after a rising clk edge; hi and lo set the pulse speed
  task automatic pulses(input int n, input int hi, input int lo);
    // two low clocks first, so a counter started just now gets armed
    repeat (2) @(posedge clk);
    repeat (n)
    begin
      pins.external_count_input <= 1'b1;
      repeat (hi) @(posedge clk);
      pins.external_count_input <= 1'b0;
      repeat (lo) @(posedge clk);
    end
  endtask

  task automatic set_gate(input logic g, input logic c);
    pins.gate_input_pin    <= g;
    pins.comparator_result <= c;
  endtask

endmodule // gtpc_pin_source

//--- dv/test_gated_16bit_timer_prescale_control.sv
// self-checking bench of the gated timer through its register slave
module test_gated_16bit_timer_prescale_control
  import gtpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [31:0]       writedata;
  logic [3:0]        byteenable;
  logic [31:0]       readdata;
  logic              waitrequest;
  gtpc_pins_type     pins;
  logic              sleep_mode;
  logic              internal_oscillator_no_clkout;
  gtpc_status_type   status;
  logic [63:0]       exp_q[$];
  logic [63:0]       e;
  logic [15:0]       base;
  int                num_errors = 0;
  int                compares = 0;
  int                wakes = 0;
  int                ovfs = 0;
  int                n;
  int                w0;
  int                o0;

  gtpc_timer u_gtpc_timer (
    .clk              (clk),
    .rst_n            (rst_n),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .byteenable       (byteenable),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .pins             (pins),
    .sleep_mode       (sleep_mode),
    .internal_oscillator_no_clkout (internal_oscillator_no_clkout),
    .status           (status)
  );

  gtpc_pin_source u_gtpc_pin_source (
    .clk  (clk),
    .pins (pins)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // checking and reporting
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (exp_q.size() != 0)
      num_errors++;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // read data is taken only at the edge that sees waitrequest low
  always @(posedge clk)
  begin
    if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      check(readdata & e[63:32], e[31:0]);
    end
    if (status.wake_request === 1'b1)
      wakes++;
    if (status.overflow_pulse === 1'b1)
      ovfs++;
  end

  initial
  begin
    #400000;
    num_errors++;
    final_report();
  end

  // ==========================================================================
  // bus tasks: request held until waitrequest is seen low
  // ==========================================================================
  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    read      <= ~we;
    write     <= we;
    address   <= a;
    writedata <= d;
    @(posedge clk);
    // only the watchdog ends a wait that never sees waitrequest low
    while (waitrequest !== 1'b0)
      @(posedge clk);
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    exp_q.push_back({m, x});
    bus(1'b0, a, 32'h0000_0000);
  endtask

  // clocks between two count steps, skipping the first partial one
  task automatic measure(input int want);
    int c;
    @(posedge clk);
    base = status.count;
    c = 0;
    while (status.count === base && c < 200)
    begin
      @(posedge clk);
      c++;
    end
    base = status.count;
    c = 0;
    while (status.count === base && c < 200)
    begin
      @(posedge clk);
      c++;
    end
    check(32'(c), 32'(want));
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial
  begin
    n = $urandom(31);
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'h1;
    sleep_mode = 1'b0;
    internal_oscillator_no_clkout = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CONTROL, 32'h0000_0000, '1);
    rd(ADDR_COMP_AUX, 32'h0000_0002, '1);
    wr(5'h14, 8'hFF);
    rd(5'h14, UNMAPPED_READ, '1);
    base = 16'($urandom);
    wr(ADDR_COUNT_LOW, base[7:0]);
    wr(ADDR_COUNT_HIGH, base[15:8]);
    repeat (20) @(posedge clk);
    rd(ADDR_COUNT_LOW, {24'h00_0000, base[7:0]}, '1);
    rd(ADDR_COUNT_HIGH, {24'h00_0000, base[15:8]}, '1);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADDR_CONTROL, {2'b00, 2'(s), 4'h1});
      measure(INSTR_CLKS << s);
    end
    wr(ADDR_CONTROL, 8'h30);
    @(posedge clk);
    base = status.count;
    repeat (40) @(posedge clk);
    check(32'(status.count), 32'(base));
    byteenable <= 4'h0;
    wr(ADDR_CONTROL, 8'hFF);
    byteenable <= 4'h1;
    rd(ADDR_CONTROL, 32'h0000_0030, '1);
    // every gate source, polarity, enable and level
    for (int i = 0; i < 16; i++)
    begin
      u_gtpc_pin_source.set_gate(i[3] ~^ i[2], i[3] ^ i[2]);
      wr(ADDR_COMP_AUX, {6'h00, i[2], 1'b0});
      wr(ADDR_CONTROL, {i[0], i[1], 6'h01});
      rd(ADDR_STATUS, {31'h0, !(i[1] & (i[3] ^ i[0]))}, 32'h1);
      check(32'(status.counting), 32'(!(i[1] & (i[3] ^ i[0]))));
    end
    wr(ADDR_CONTROL, 8'h08);
    internal_oscillator_no_clkout <= 1'b1;
    rd(ADDR_STATUS, 32'h0000_0004, 32'h4);
    internal_oscillator_no_clkout <= 1'b0;
    rd(ADDR_STATUS, 32'h0000_0000, 32'h4);
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, {5'h00, 1'(m), 2'b11});
      n = 1 + $urandom % 12;
      u_gtpc_pin_source.pulses(n, 2 + $urandom % 4, 2 + $urandom % 4);
      repeat (6) @(posedge clk);
      rd(ADDR_COUNT_LOW, 32'(n), '1);
    end
    // sleep: only the unsynchronised counter runs and wakes the core
    sleep_mode <= 1'b1;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hFF);
    wr(ADDR_COUNT_HIGH, 8'hFF);
    wr(ADDR_CONTROL, 8'h03);
    u_gtpc_pin_source.pulses(3, 3, 3);
    repeat (4) @(posedge clk);
    check(32'(status.count), 32'h0000_FFFF);
    w0 = wakes;
    o0 = ovfs;
    wr(ADDR_CONTROL, 8'h07);
    u_gtpc_pin_source.pulses(1, 3, 3);
    repeat (4) @(posedge clk);
    check(32'(status.count), 32'h0000_0000);
    check(32'(wakes - w0), 32'h0000_0001);
    check(32'(ovfs - o0), 32'h0000_0001);
    sleep_mode <= 1'b0;
    // divider residue of 5 must be dropped by the count write
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h37);
    u_gtpc_pin_source.pulses(5, 2, 2);
    wr(ADDR_COUNT_LOW, 8'h40);
    u_gtpc_pin_source.pulses(7, 2, 2);
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT_LOW, 32'h0000_0040, '1);
    u_gtpc_pin_source.pulses(1, 2, 2);
    repeat (6) @(posedge clk);
    rd(ADDR_COUNT_LOW, 32'h0000_0041, '1);
    repeat (4) @(posedge clk);
    final_report();
  end

endmodule // test_gated_16bit_timer_prescale_control
